// ===== dv/mdio_host.sv
// Management bus host model driving serial clock and data
`timescale 1ns/1ps
module mdio_host (
	input  wire clk,
	output reg  mdc,
	output wire mdioIn,
	input  wire mdioOut,
	input  wire mdioOe_n
);
	reg hostBit;
	// Pulled-up wire, device wins while enabled
	assign mdioIn = mdioOe_n ? hostBit : mdioOut;
	initial begin
		mdc = 1'b0;
		hostBit = 1'b1;
	end
	// One whole frame, clock idle low between frames
	task xfer(input [1:0] op, input [15:0] d, output [15:0] q);
		reg [63:0] f;
		integer i;
		begin
			f = {32'hFFFFFFFF, 2'b00, op, 5'h00, 5'h1F, 2'b10, d};
			for (i = 63; i >= 0; i = i - 1) begin
				hostBit = (op[1] && i < 18) ? 1'b1 : f[i];
				repeat (8) @(negedge clk);
				mdc = 1'b1;
				if (i < 16)
					q[i] = mdioIn;
				repeat (8) @(negedge clk);
				mdc = 1'b0;
			end
			hostBit = 1'b1;
		end
	endtask
endmodule // mdio_host

// ===== dv/phy_irq_fc_stats_props.sv
// Port-level checker for the interrupt and frame checker block
`timescale 1ns/1ps
module phy_irq_fc_stats_props (
	input wire sys_clk,
	input wire srst,
	input wire mdc,
	input wire mdioOut,
	input wire mdioOe_n,
	input wire linkChange,
	input wire autonegChange,
	input wire bufferError,
	input wire rxFrameDone,
	input wire txFrameDone,
	input wire irqOut,
	input wire fatalError
);
	wire anyEvt;
	assign anyEvt = linkChange | autonegChange | bufferError | rxFrameDone | txFrameDone;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);
	property p_link; linkChange |=> irqOut; endproperty
	a_link: assert property (p_link) else $error("link event gave no irq");
	property p_buf; bufferError |=> irqOut; endproperty
	a_buf: assert property (p_buf) else $error("buffer event gave no irq");
	property p_fatal; !fatalError; endproperty
	a_fatal: assert property (p_fatal) else $error("fatal flag raised");
	property p_fall; $fell(irqOut) |-> ##[1:40] $fell(mdioOe_n); endproperty
	a_fall: assert property (p_fall) else $error("irq dropped without read");
	property p_rise; $rose(irqOut) |-> $past(anyEvt) || $past(mdc); endproperty
	a_rise: assert property (p_rise) else $error("irq rose without cause");
	property p_rst; disable iff (1'b0) srst |=> !irqOut && mdioOe_n && !fatalError; endproperty
	a_rst: assert property (p_rst) else $error("reset outputs wrong");
	property p_len; $fell(mdioOe_n) |-> ##[270:274] $rose(mdioOe_n); endproperty
	a_len: assert property (p_len) else $error("read drive length wrong");
	property p_ta; $fell(mdioOe_n) |-> !mdioOut; endproperty
	a_ta: assert property (p_ta) else $error("turnaround bit not zero");
endmodule // phy_irq_fc_stats_props
bind phy_irq_fc_stats phy_irq_fc_stats_props u_props (.*);

// ===== dv/tb_phy_irq_fc_stats.sv
// Self-checking bench for the interrupt and frame checker block
`timescale 1ns/1ps
`include "phy_mgmt_regs.vh"
module tb_phy_irq_fc_stats;
	reg        sys_clk = 1'b0;
	reg        srst    = 1'b1;
	reg [10:0] ev      = 11'h000;
	reg [15:0] q, expSt = 16'h0000, err = 16'h0000, len = 16'h0000, aln = 16'h0000;
	reg [31:0] frm     = 32'h00000000;
	reg        en = 1'b1, ien = 1'b1, sel = 1'b0;
	wire       mdc, mdioIn, mdioOut, mdioOe_n, irqOut, fatalError;
	integer    n_errors = 0, n_checks = 0, cyc = 0, i;
	always #5 sys_clk = ~sys_clk;
	phy_irq_fc_stats dut (.sys_clk(sys_clk), .srst(srst), .mdc(mdc), .mdioIn(mdioIn),
		.mdioOut(mdioOut), .mdioOe_n(mdioOe_n), .linkChange(ev[0]), .autonegChange(ev[1]),
		.bufferError(ev[2]), .rxFrameDone(ev[3]), .rxCrcError(ev[4]), .rxLenError(ev[5]),
		.rxAlignError(ev[6]), .txFrameDone(ev[7]), .txCrcError(ev[8]), .txLenError(ev[9]),
		.txAlignError(ev[10]), .irqOut(irqOut), .fatalError(fatalError));
	mdio_host host (.clk(sys_clk), .mdc(mdc), .mdioIn(mdioIn), .mdioOut(mdioOut),
		.mdioOe_n(mdioOe_n));
	task summarize;
		begin
			$display("checks=%0d errors=%0d", n_checks, n_errors);
			if (n_errors == 0 && n_checks > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask
	task chk(input [15:0] s, input [15:0] e);
		begin
			n_checks = n_checks + 1;
			if (s !== e) begin
				n_errors = n_errors + 1;
				$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
			end
		end
	endtask
	task acc(input [1:0] op, input [15:0] a, input [15:0] d);
		begin
			host.xfer(`MDIO_OP_ADDR, a, q);
			host.xfer(op, d, q);
		end
	endtask
	function [15:0] stat(input [15:0] s, input [2:0] e);
		stat = s | {2'b00, e[2], 1'b0, e[1], 9'h000, e[0], 1'b0};
	endfunction
	task pulse(input [10:0] v);
		begin
			ev = v;
			@(negedge sys_clk);
			ev = 11'h000;
			@(negedge sys_clk);
		end
	endtask
	task stim(input integer n);
		reg [10:0] v;
		reg [2:0]  c;
		reg        t;
		begin
			repeat (n) begin
				v = $urandom;
				pulse(v);
				expSt = stat(expSt, v[2:0]);
				t = sel ? v[7] : v[3];
				c = sel ? v[10:8] : v[6:4];
				if (t && en) begin
					frm = frm + 1;
					err = err + (|c);
					len = len + c[1];
					aln = aln + c[2];
					expSt[14] = expSt[14] | ((|c) & ien);
				end
			end
		end
	endtask
	task snap;
		begin
			acc(`MDIO_OP_READ_INC, `OFS_RECEIVE_ERROR_COUNT, 16'h0000);
			chk(q, err);
			err = 16'h0000;
			host.xfer(`MDIO_OP_READ_INC, 16'h0000, q);
			chk(q, frm[31:16]);
			host.xfer(`MDIO_OP_READ_INC, 16'h0000, q);
			chk(q, frm[15:0]);
			host.xfer(`MDIO_OP_READ_INC, 16'h0000, q);
			chk(q, len);
			host.xfer(`MDIO_OP_READ, 16'h0000, q);
			chk(q, aln);
		end
	endtask
	task rdst;
		begin
			acc(`MDIO_OP_READ, `OFS_IRQ_STATUS, 16'h0000);
			chk(q, expSt);
			expSt = 16'h0000;
		end
	endtask
	always @(posedge sys_clk) begin
		cyc = cyc + 1;
		if (cyc == 90000) begin
			n_errors = n_errors + 1;
			summarize;
		end
	end
	initial begin
		i = $urandom(18968);
		repeat (20) @(negedge sys_clk);
		srst = 1'b0;
		repeat (4) @(negedge sys_clk);
		acc(`MDIO_OP_READ, `OFS_IRQ_MASK, 16'h0000);
		chk(q, 16'h2402);
		acc(`MDIO_OP_READ, `OFS_CHK_EN, 16'h0000);
		chk(q, 16'h0001);
		acc(`MDIO_OP_READ, `OFS_CHK_IRQ_EN, 16'h0000);
		chk(q, 16'h0001);
		acc(`MDIO_OP_READ, 16'h8002, 16'h0000);
		chk(q, 16'h0000);
		acc(`MDIO_OP_READ, `OFS_CHK_SRC_SEL, 16'h0000);
		chk(q, 16'h0000);
		snap;
		stim(40);
		rdst;
		chk({15'h0000, irqOut}, 16'h0000);
		for (i = 0; i < 4; i = i + 1) begin
			fork
				acc(`MDIO_OP_READ, `OFS_IRQ_STATUS, 16'h0000);
				begin
					repeat (1753 + i) @(negedge sys_clk);
					pulse(11'h001);
				end
			join
			expSt = q;
			acc(`MDIO_OP_READ, `OFS_IRQ_STATUS, 16'h0000);
			chk((expSt | q) & 16'h0002, 16'h0002);
		end
		expSt = 16'h0000;
		acc(`MDIO_OP_WRITE, `OFS_IRQ_MASK, 16'h2002);
		pulse(11'h002);
		chk({15'h0000, irqOut}, 16'h0000);
		expSt = 16'h0800;
		rdst;
		snap;
		sel = 1'b1;
		acc(`MDIO_OP_WRITE, `OFS_CHK_SRC_SEL, 16'h0001);
		stim(40);
		acc(`MDIO_OP_WRITE, `OFS_IRQ_MASK, 16'h6802);
		repeat (2) @(negedge sys_clk);
		chk({15'h0000, irqOut}, {15'h0000, |expSt});
		rdst;
		snap;
		en = 1'b0;
		acc(`MDIO_OP_WRITE, `OFS_CHK_EN, 16'h0000);
		stim(10);
		en = 1'b1;
		acc(`MDIO_OP_WRITE, `OFS_CHK_EN, 16'h0001);
		ien = 1'b0;
		acc(`MDIO_OP_WRITE, `OFS_CHK_IRQ_EN, 16'h0000);
		stim(20);
		rdst;
		snap;
		summarize;
	end
endmodule // tb_phy_irq_fc_stats

// ===== hw/mdio_c45_slave.v
// Clause 45 management serial slave, sampled by the system clock
`timescale 1ns/1ps
`include "phy_mgmt_regs.vh"
module mdio_c45_slave #(
	parameter [4:0] PHY_ADDR = 5'h00
) (
	input  wire        sys_clk,
	input  wire        srst,
	input  wire        mdc,
	input  wire        mdioIn,
	output reg         mdioOut,
	output reg         mdioOe_n,
	output reg  [15:0] regAddr,
	output reg  [15:0] wrData,
	output reg         wrStrobe,
	output reg         rdStrobe,
	input  wire [15:0] rdData
);

localparam [3:0] S_PRE  = 4'h1;
localparam [3:0] S_HDR  = 4'h2;
localparam [3:0] S_TA   = 4'h4;
localparam [3:0] S_DATA = 4'h8;

wire [1:0]  pins;
reg         mdcLast_r;
reg  [3:0]  state_r;
reg  [5:0]  preCnt_r;
reg  [3:0]  cnt_r;
reg  [11:0] hdr_r;
reg  [1:0]  op_r;
reg         match_r;
reg         readOp_r;
reg         rdLoad_r;
reg  [15:0] txShift_r;
wire        mdcS   = pins[1];
wire        mdioS  = pins[0];
wire        rise   = mdcS & ~mdcLast_r;
wire        fall   = ~mdcS & mdcLast_r;
wire [12:0] hdrFull = {hdr_r, mdioS};
wire        hdrHit = ~hdrFull[12] && hdrFull[9:5] == PHY_ADDR && hdrFull[4:0] == `MDIO_DEVAD;

sync2 #(.WIDTH(2)) u_sync (
	.sys_clk (sys_clk),
	.srst    (srst),
	.asyncIn ({mdc, mdioIn}),
	.syncOut (pins)
);

always @(posedge sys_clk) begin
	if (srst) begin
		mdcLast_r <= 1'b0;
		state_r   <= S_PRE;
		preCnt_r  <= 6'h00;
		cnt_r     <= 4'h0;
		hdr_r     <= 12'h000;
		op_r      <= 2'h0;
		match_r   <= 1'b0;
		readOp_r  <= 1'b0;
		rdLoad_r  <= 1'b0;
		txShift_r <= 16'h0000;
		regAddr   <= 16'h0000;
		wrData    <= 16'h0000;
		wrStrobe  <= 1'b0;
		rdStrobe  <= 1'b0;
		mdioOut   <= 1'b1;
		mdioOe_n  <= 1'b1;
	end else begin
		mdcLast_r <= mdcS;
		wrStrobe  <= 1'b0;
		rdStrobe  <= 1'b0;
		rdLoad_r  <= rdStrobe;
		if (rdLoad_r) begin
			txShift_r <= rdData;
		end
		if (rise) begin
			case (state_r)
				S_PRE: begin
					if (mdioS) begin
						if (preCnt_r != `MDIO_PRE_BITS)
							preCnt_r <= preCnt_r + 6'h01;
					end else if (preCnt_r == `MDIO_PRE_BITS) begin
						state_r <= S_HDR;
						cnt_r   <= 4'h0;
					end else begin
						preCnt_r <= 6'h00;
					end
				end
				S_HDR: begin
					hdr_r <= hdrFull[11:0];
					cnt_r <= cnt_r + 4'h1;
					if (cnt_r == 4'hC) begin
						op_r     <= hdrFull[11:10];
						match_r  <= hdrFull[12] ? 1'b0 : hdrHit;
						readOp_r <= hdrHit && hdrFull[11];
						rdStrobe <= hdrHit && hdrFull[11];
						state_r  <= S_TA;
						cnt_r    <= 4'h0;
					end
				end
				S_TA: begin
					cnt_r <= cnt_r + 4'h1;
					if (cnt_r == 4'h1) begin
						state_r <= S_DATA;
						cnt_r   <= 4'h0;
					end
				end
				S_DATA: begin
					wrData <= {wrData[14:0], mdioS};
					cnt_r  <= cnt_r + 4'h1;
					if (cnt_r == 4'hF) begin
						if (match_r && op_r == `MDIO_OP_ADDR)
							regAddr <= {wrData[14:0], mdioS};
						if (match_r && op_r == `MDIO_OP_WRITE)
							wrStrobe <= 1'b1;
						if (match_r && op_r == `MDIO_OP_READ_INC)
							regAddr <= regAddr + 16'h0001;
						state_r  <= S_PRE;
						preCnt_r <= 6'h00;
						readOp_r <= 1'b0;
						match_r  <= 1'b0;
					end
				end
				default: begin
					state_r <= S_PRE;
				end
			endcase
		end
		if (fall) begin
			if (readOp_r && state_r == S_TA && cnt_r == 4'h1) begin
				mdioOe_n <= 1'b0;
				mdioOut  <= 1'b0;
			end else if (readOp_r && state_r == S_DATA) begin
				mdioOe_n  <= 1'b0;
				mdioOut   <= txShift_r[15];
				txShift_r <= {txShift_r[14:0], 1'b0};
			end else begin
				mdioOe_n <= 1'b1;
				mdioOut  <= 1'b1;
			end
		end
	end
end

endmodule // mdio_c45_slave

// ===== hw/phy_irq_fc_stats.v
// Interrupt status and mask, frame checker counters and snapshots
`timescale 1ns/1ps
`include "phy_mgmt_regs.vh"
module phy_irq_fc_stats #(
	parameter [4:0] PHY_ADDR = 5'h00
) (
	input  wire sys_clk,
	input  wire srst,
	input  wire mdc,
	input  wire mdioIn,
	output wire mdioOut,
	output wire mdioOe_n,
	input  wire linkChange,
	input  wire autonegChange,
	input  wire bufferError,
	input  wire rxFrameDone,
	input  wire rxCrcError,
	input  wire rxLenError,
	input  wire rxAlignError,
	input  wire txFrameDone,
	input  wire txCrcError,
	input  wire txLenError,
	input  wire txAlignError,
	output reg  irqOut,
	output reg  fatalError
);

wire [15:0] regAddr;
wire [15:0] wrData;
wire        wrStrobe;
wire        rdStrobe;
reg  [15:0] rdData_r;

reg  [15:0] irqStatus_r;
reg  [15:0] irqStatus_nxt;
reg  [15:0] irqMask_r;
reg         chkEnable_r;
reg         chkIrqEnable_r;
reg         chkSrcSel_r;
reg  [31:0] frameCnt_r;
reg  [15:0] rxErrCnt_r;
reg  [15:0] lenErrCnt_r;
reg  [15:0] alignErrCnt_r;
reg  [15:0] frmSnapHi_r;
reg  [15:0] frmSnapLo_r;
reg  [15:0] lenSnap_r;
reg  [15:0] alignSnap_r;
reg  [15:0] events;

reg         selDone;
reg         selCrc;
reg         selLen;
reg         selAlign;
wire        frameSeen;
wire        frameBad;
wire        chkEvent;
wire        rdStatus;
wire        rdErrCnt;
wire        hitStatus;
wire        hitMask;
wire        hitChkEn;
wire        hitChkIrqEn;
wire        hitSrcSel;
wire        hitErrCnt;
wire        hitFrmHi;
wire        hitFrmLo;
wire        hitLenSnap;
wire        hitAlignSnap;
reg  [15:0] rxErrCnt_nxt;

mdio_c45_slave #(.PHY_ADDR(PHY_ADDR)) u_mdio (
	.sys_clk  (sys_clk),
	.srst     (srst),
	.mdc      (mdc),
	.mdioIn   (mdioIn),
	.mdioOut  (mdioOut),
	.mdioOe_n (mdioOe_n),
	.regAddr  (regAddr),
	.wrData   (wrData),
	.wrStrobe (wrStrobe),
	.rdStrobe (rdStrobe),
	.rdData   (rdData_r)
);

// Frame source selection
always @* begin
	if (chkSrcSel_r) begin
		selDone  = txFrameDone;
		selCrc   = txCrcError;
		selLen   = txLenError;
		selAlign = txAlignError;
	end else begin
		selDone  = rxFrameDone;
		selCrc   = rxCrcError;
		selLen   = rxLenError;
		selAlign = rxAlignError;
	end
end

assign frameSeen = chkEnable_r & selDone;
assign frameBad  = frameSeen & (selCrc | selLen | selAlign);
assign chkEvent  = frameBad & chkIrqEnable_r;
assign rdStatus  = rdStrobe & hitStatus;
assign rdErrCnt  = rdStrobe & hitErrCnt;

// Register address decode
assign hitStatus    = (regAddr == `OFS_IRQ_STATUS);
assign hitMask      = (regAddr == `OFS_IRQ_MASK);
assign hitChkEn     = (regAddr == `OFS_CHK_EN);
assign hitChkIrqEn  = (regAddr == `OFS_CHK_IRQ_EN);
assign hitSrcSel    = (regAddr == `OFS_CHK_SRC_SEL);
assign hitErrCnt    = (regAddr == `OFS_RECEIVE_ERROR_COUNT);
assign hitFrmHi     = (regAddr == `OFS_FRM_SNAP_HI);
assign hitFrmLo     = (regAddr == `OFS_FRM_SNAP_LO);
assign hitLenSnap   = (regAddr == `OFS_LEN_ERR_SNAP);
assign hitAlignSnap = (regAddr == `OFS_ALGN_ERR_SNAP);

// Event vector; reserved positions have no source
always @* begin
	events = 16'h0000;
	events[`BIT_CHECKER_EVT] = chkEvent;
	events[`BIT_BUFFER_ERR]  = bufferError;
	events[`BIT_AUTONEG_CHG] = autonegChange;
	events[`BIT_LINK_CHG]    = linkChange;
end

// Latched-high status, read clears, set wins
always @* begin
	if (rdStatus)
		irqStatus_nxt = events;
	else
		irqStatus_nxt = irqStatus_r | events;
end

// Latched status register
always @(posedge sys_clk) begin
	if (srst) begin
		irqStatus_r <= `RST_IRQ_STATUS;
	end else begin
		irqStatus_r <= irqStatus_nxt;
	end
end

// Mask register, top bit self-clears
always @(posedge sys_clk) begin
	if (srst) begin
		irqMask_r <= `RST_IRQ_MASK;
	end else if (wrStrobe && hitMask) begin
		irqMask_r <= wrData;
	end else begin
		irqMask_r[`BIT_MASK_SC] <= 1'b0;
	end
end

// Interrupt and fatal outputs
always @(posedge sys_clk) begin
	if (srst) begin
		irqOut     <= 1'b0;
		fatalError <= 1'b0;
	end else begin
		irqOut     <= |(irqStatus_nxt & irqMask_r);
		fatalError <= |(irqStatus_nxt & `IRQ_RSVD_BITS);
	end
end

// Checker enable
always @(posedge sys_clk) begin
	if (srst) begin
		chkEnable_r <= `RST_CHK_EN;
	end else if (wrStrobe && hitChkEn) begin
		chkEnable_r <= wrData[0];
	end
end

// Checker interrupt enable
always @(posedge sys_clk) begin
	if (srst) begin
		chkIrqEnable_r <= `RST_CHK_IRQ_EN;
	end else if (wrStrobe && hitChkIrqEn) begin
		chkIrqEnable_r <= wrData[0];
	end
end

// Checker source select
always @(posedge sys_clk) begin
	if (srst) begin
		chkSrcSel_r <= `RST_CHK_SRC_SEL;
	end else if (wrStrobe && hitSrcSel) begin
		chkSrcSel_r <= wrData[0];
	end
end

// Live frame counter
always @(posedge sys_clk) begin
	if (srst) begin
		frameCnt_r <= 32'h00000000;
	end else if (frameSeen) begin
		frameCnt_r <= frameCnt_r + 32'h00000001;
	end
end

// Live length error counter
always @(posedge sys_clk) begin
	if (srst) begin
		lenErrCnt_r <= 16'h0000;
	end else if (frameSeen && selLen) begin
		lenErrCnt_r <= lenErrCnt_r + 16'h0001;
	end
end

// Live alignment error counter
always @(posedge sys_clk) begin
	if (srst) begin
		alignErrCnt_r <= 16'h0000;
	end else if (frameSeen && selAlign) begin
		alignErrCnt_r <= alignErrCnt_r + 16'h0001;
	end
end

// Receive error count, read clears, set wins
always @* begin
	if (rdErrCnt)
		rxErrCnt_nxt = frameBad ? 16'h0001 : 16'h0000;
	else if (frameBad)
		rxErrCnt_nxt = rxErrCnt_r + 16'h0001;
	else
		rxErrCnt_nxt = rxErrCnt_r;
end

always @(posedge sys_clk) begin
	if (srst) begin
		rxErrCnt_r <= 16'h0000;
	end else begin
		rxErrCnt_r <= rxErrCnt_nxt;
	end
end

// Snapshots taken by the receive error count read
always @(posedge sys_clk) begin
	if (srst) begin
		frmSnapHi_r <= 16'h0000;
		frmSnapLo_r <= 16'h0000;
		lenSnap_r   <= 16'h0000;
		alignSnap_r <= 16'h0000;
	end else if (rdErrCnt) begin
		frmSnapHi_r <= frameCnt_r[31:16];
		frmSnapLo_r <= frameCnt_r[15:0];
		lenSnap_r   <= lenErrCnt_r;
		alignSnap_r <= alignErrCnt_r;
	end
end

// Read data mux, unmapped reads as zero
always @(posedge sys_clk) begin
	if (srst) begin
		rdData_r <= 16'h0000;
	end else if (rdStrobe) begin
		if (regAddr == `OFS_IRQ_STATUS)
			rdData_r <= irqStatus_r;
		else if (regAddr == `OFS_IRQ_MASK)
			rdData_r <= irqMask_r;
		else if (regAddr == `OFS_CHK_EN)
			rdData_r <= {15'h0000, chkEnable_r};
		else if (regAddr == `OFS_CHK_IRQ_EN)
			rdData_r <= {15'h0000, chkIrqEnable_r};
		else if (regAddr == `OFS_CHK_SRC_SEL)
			rdData_r <= {15'h0000, chkSrcSel_r};
		else if (regAddr == `OFS_RECEIVE_ERROR_COUNT)
			rdData_r <= rxErrCnt_r;
		else if (regAddr == `OFS_FRM_SNAP_HI)
			rdData_r <= frmSnapHi_r;
		else if (regAddr == `OFS_FRM_SNAP_LO)
			rdData_r <= frmSnapLo_r;
		else if (regAddr == `OFS_LEN_ERR_SNAP)
			rdData_r <= lenSnap_r;
		else if (regAddr == `OFS_ALGN_ERR_SNAP)
			rdData_r <= alignSnap_r;
		else
			rdData_r <= 16'h0000;
	end
end

endmodule // phy_irq_fc_stats

// ===== hw/phy_mgmt_regs.vh
// Register offsets, field positions, reset values and timing counts
`ifndef PHY_MGMT_REGS_VH
`define PHY_MGMT_REGS_VH

`define MDIO_DEVAD        5'h1F
`define MDIO_PRE_BITS     6'h20
`define MDIO_OP_ADDR      2'h0
`define MDIO_OP_WRITE     2'h1
`define MDIO_OP_READ_INC  2'h2
`define MDIO_OP_READ      2'h3

`define OFS_IRQ_STATUS    16'h0011
`define OFS_IRQ_MASK      16'h0021
`define OFS_CHK_EN        16'h8001
`define OFS_CHK_IRQ_EN    16'h8004
`define OFS_CHK_SRC_SEL   16'h8005
`define OFS_RECEIVE_ERROR_COUNT    16'h8008
`define OFS_FRM_SNAP_HI   16'h8009
`define OFS_FRM_SNAP_LO   16'h800A
`define OFS_LEN_ERR_SNAP  16'h800B
`define OFS_ALGN_ERR_SNAP 16'h800C

`define BIT_CHECKER_EVT   14
`define BIT_BUFFER_ERR    13
`define BIT_AUTONEG_CHG   11
`define BIT_LINK_CHG      1
`define BIT_MASK_SC       15
`define IRQ_USED_BITS     16'h6802
`define IRQ_RSVD_BITS     16'h97FD

`define RST_IRQ_STATUS    16'h0000
`define RST_IRQ_MASK      16'h2402
`define RST_CHK_EN        1'b1
`define RST_CHK_IRQ_EN    1'b1
`define RST_CHK_SRC_SEL   1'b0

`endif

// ===== hw/sync2.v
// Two-flop synchroniser for signals from outside the clock domain
`timescale 1ns/1ps
module sync2 #(
	parameter WIDTH = 1
) (
	input  wire             sys_clk,
	input  wire             srst,
	input  wire [WIDTH-1:0] asyncIn,
	output reg  [WIDTH-1:0] syncOut
);

reg [WIDTH-1:0] meta_r;

always @(posedge sys_clk) begin
	if (srst) begin
		meta_r  <= {WIDTH{1'b0}};
		syncOut <= {WIDTH{1'b0}};
	end else begin
		meta_r  <= asyncIn;
		syncOut <= meta_r;
	end
end

endmodule // sync2
